// ===== rtl/pcm_defs.vh
`ifndef PCM_DEFS_VH
`define PCM_DEFS_VH

// Operand and result widths accepted by the multiplier
`define PCM_WIDTH_MIN        1
`define PCM_WIDTH_MAX        256
`define PCM_WIDTH_A_DEFAULT  16
`define PCM_WIDTH_B_DEFAULT  16
`define PCM_WIDTH_R_DEFAULT  33

// Output latency in clock cycles
`define PCM_LATENCY_MIN      0
`define PCM_LATENCY_MAX      14
`define PCM_LATENCY_DEFAULT  4

// Operand representation: 1 = signed two's complement, 0 = unsigned
`define PCM_REPR_UNSIGNED    0
`define PCM_REPR_SIGNED      1

// Optional controls: 1 = input honoured, 0 = input ignored
`define PCM_OPT_OFF          0
`define PCM_OPT_ON           1

// Value loaded into every output_latency_cycles stage on a clear
`define PCM_CLEAR_VALUE      1'b0

// Stages of the reset release synchroniser
`define PCM_RST_SYNC_STAGES  2

`endif

// ===== rtl/pcm_delay_line.v
`timescale 1ns/1ps
`default_nettype none

`include "pcm_defs.vh"

// Chain of DEPTH registers; the tap comes straight from the last stage
module pcm_delay_line #(
  parameter integer WIDTH = 32,
  parameter integer DEPTH = 1
) (
  input  wire             clk_in,
  input  wire             clear_async_in,
  input  wire             clear_sync_in,
  input  wire             advance_in,
  input  wire [WIDTH-1:0] data_in,
  output wire [WIDTH-1:0] data_out
);

  reg [WIDTH-1:0] stage [0:DEPTH-1];
  integer         i;

  always @(posedge clk_in or posedge clear_async_in) begin
    if (clear_async_in) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage[i] <= {WIDTH{`PCM_CLEAR_VALUE}};
      end
    end else if (clear_sync_in) begin
      // Clear wins over a stalled enable so a held pipe can still be flushed
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage[i] <= {WIDTH{`PCM_CLEAR_VALUE}};
      end
    end else if (advance_in) begin
      stage[0] <= data_in;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign data_out = stage[DEPTH-1];

endmodule

`default_nettype wire

// ===== rtl/pcm_complex_mult.v
`timescale 1ns/1ps
`default_nettype none

`include "pcm_defs.vh"

// Behaviour
// - A operand width, real and imaginary, is a parameter from 1 to 256.
// - B operand width, real and imaginary, is a parameter from 1 to 256.
// - Each product output width is a parameter from 1 to 256.
// - A parameter selects signed or unsigned reading of A parts.
// - A parameter selects signed or unsigned reading of B parts.
// - Operand to product latency is a parameter from 0 to 14 cycles.
// - Optional asynchronous clear empties output_latency_cycles and, at latency 1 or more, outputs at once.
// - Optional synchronous clear empties output_latency_cycles and, at latency 1 or more, outputs on the clock.
// - Optional active-high clock enable; low holds every output_latency_cycles register.
// - Real product appears on an output of the result width.
// - Imaginary product appears on an output of the result width.
module pcm_complex_mult #(
  parameter integer WIDTH_A        = `PCM_WIDTH_A_DEFAULT,
  parameter integer WIDTH_B        = `PCM_WIDTH_B_DEFAULT,
  parameter integer WIDTH_RESULT   = `PCM_WIDTH_R_DEFAULT,
  parameter integer a_signedness   = `PCM_REPR_SIGNED,
  parameter integer b_signedness   = `PCM_REPR_SIGNED,
  parameter integer output_latency_cycles = `PCM_LATENCY_DEFAULT,
  parameter integer USE_ACLR       = `PCM_OPT_ON,
  parameter integer USE_SCLR       = `PCM_OPT_ON,
  parameter integer USE_ENA        = `PCM_OPT_ON
) (
  input  wire                    ref_clk_in,
  input  wire                    rst_n_in,
  input  wire                    aclr_in,
  input  wire                    sclr_in,
  input  wire                    ena_in,
  input  wire [WIDTH_A-1:0]      a_real_in,
  input  wire [WIDTH_A-1:0]      a_imag_in,
  input  wire [WIDTH_B-1:0]      b_real_in,
  input  wire [WIDTH_B-1:0]      b_imag_in,
  output wire [WIDTH_RESULT-1:0] result_real_out,
  output wire [WIDTH_RESULT-1:0] result_imag_out
);

  // Internal width: wide enough that neither product nor sum can overflow,
  // even for two unsigned full-scale operands
  localparam integer WIDTH_INT = WIDTH_A + WIDTH_B + 2;
  localparam integer EXT_A     = WIDTH_INT - WIDTH_A;
  localparam integer EXT_B     = WIDTH_INT - WIDTH_B;
  localparam integer PIPE_W    = 2 * WIDTH_RESULT;

  reg  [`PCM_RST_SYNC_STAGES-1:0] rst_sync;
  wire                            rst_n;
  wire                            clear_async;
  wire                            clear_sync;
  wire                            advance;

  wire [WIDTH_INT-1:0]            ar_ext;
  wire [WIDTH_INT-1:0]            ai_ext;
  wire [WIDTH_INT-1:0]            br_ext;
  wire [WIDTH_INT-1:0]            bi_ext;
  wire [WIDTH_INT-1:0]            real_full;
  wire [WIDTH_INT-1:0]            imag_full;
  wire [WIDTH_RESULT-1:0]         real_fit;
  wire [WIDTH_RESULT-1:0]         imag_fit;

  // Widen an operand to the internal width; only signed operands copy the MSB
  function [WIDTH_INT-1:0] widen_a;
    input [WIDTH_A-1:0] value;
    begin
      widen_a = {{EXT_A{(a_signedness == `PCM_REPR_SIGNED) & value[WIDTH_A-1]}}, value};
    end
  endfunction

  function [WIDTH_INT-1:0] widen_b;
    input [WIDTH_B-1:0] value;
    begin
      widen_b = {{EXT_B{(b_signedness == `PCM_REPR_SIGNED) & value[WIDTH_B-1]}}, value};
    end
  endfunction

  // Two's complement product kept at the internal width; exact by construction
  function [WIDTH_INT-1:0] mul_int;
    input [WIDTH_INT-1:0] x;
    input [WIDTH_INT-1:0] y;
    reg   [2*WIDTH_INT-1:0] full;
    begin
      full    = $signed(x) * $signed(y);
      mul_int = full[WIDTH_INT-1:0];
    end
  endfunction

  // Result bits past the internal width repeat its sign bit
  function [WIDTH_RESULT-1:0] fit_result;
    input [WIDTH_INT-1:0] value;
    integer               k;
    begin
      for (k = 0; k < WIDTH_RESULT; k = k + 1) begin
        if (k < WIDTH_INT) begin
          fit_result[k] = value[k];
        end else begin
          fit_result[k] = value[WIDTH_INT-1];
        end
      end
    end
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= {`PCM_RST_SYNC_STAGES{1'b0}};
    end else begin
      rst_sync <= {rst_sync[`PCM_RST_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = rst_sync[`PCM_RST_SYNC_STAGES-1];

  // Disabled options are tied off here so the ports may be left at zero
  assign clear_async = (!rst_n) | ((USE_ACLR == `PCM_OPT_ON) & aclr_in);
  assign clear_sync  = (USE_SCLR == `PCM_OPT_ON) & sclr_in;
  assign advance     = (USE_ENA != `PCM_OPT_ON) | ena_in;

  assign ar_ext = widen_a(a_real_in);
  assign ai_ext = widen_a(a_imag_in);
  assign br_ext = widen_b(b_real_in);
  assign bi_ext = widen_b(b_imag_in);

  assign real_full = mul_int(ar_ext, br_ext) - mul_int(ai_ext, bi_ext);
  assign imag_full = mul_int(ar_ext, bi_ext) + mul_int(ai_ext, br_ext);

  // Fit to the result width: keep the low bits, or sign-extend when wider
  assign real_fit = fit_result(real_full);
  assign imag_fit = fit_result(imag_full);

  // Latency is applied after the multiply; a deep retimable chain is
  // traded for a simpler structure that synthesis can still balance
  generate
    if (output_latency_cycles == 0) begin : g_comb
      // No stage at all, so clears and enable have nothing to act on
      assign result_real_out = real_fit;
      assign result_imag_out = imag_fit;
    end else begin : g_pipe
      wire [PIPE_W-1:0] pipe_out;

      pcm_delay_line #(
        .WIDTH (PIPE_W),
        .DEPTH (output_latency_cycles)
      ) u_delay (
        .clk_in         (ref_clk_in),
        .clear_async_in (clear_async),
        .clear_sync_in  (clear_sync),
        .advance_in     (advance),
        .data_in        ({real_fit, imag_fit}),
        .data_out       (pipe_out)
      );

      assign result_real_out = pipe_out[PIPE_W-1:WIDTH_RESULT];
      assign result_imag_out = pipe_out[WIDTH_RESULT-1:0];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== bench/pcm_fabric.sv
`timescale 1ns/1ps
`default_nettype none
// Operands follow pattern_in one edge late, as registered fabric would
module pcm_fabric (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] pattern_in,
  output var  logic [7:0] a_real_out,
  output var  logic [7:0] a_imag_out,
  output var  logic [7:0] b_real_out,
  output var  logic [7:0] b_imag_out
);
  initial {a_real_out, a_imag_out, b_real_out, b_imag_out} = '0;
  always @(posedge ref_clk_in) begin
    a_real_out <= pattern_in;
    a_imag_out <= ~pattern_in;
    b_real_out <= pattern_in ^ 8'h5A;
    b_imag_out <= pattern_in + 8'h03;
  end
endmodule
`default_nettype wire

// ===== bench/pcm_complex_mult_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_props #(
  parameter integer WIDTH_A               = 8,
  parameter integer WIDTH_B               = 8,
  parameter integer WIDTH_RESULT          = 18,
  parameter integer a_signedness          = 1,
  parameter integer b_signedness          = 1,
  parameter integer output_latency_cycles = 2
) (
  input wire logic                    ref_clk_in,
  input wire logic                    rst_n_in,
  input wire logic                    aclr_in,
  input wire logic                    sclr_in,
  input wire logic                    ena_in,
  input wire logic [WIDTH_A-1:0]      a_real_in,
  input wire logic [WIDTH_A-1:0]      a_imag_in,
  input wire logic [WIDTH_B-1:0]      b_real_in,
  input wire logic [WIDTH_B-1:0]      b_imag_in,
  input wire logic [WIDTH_RESULT-1:0] result_real_out,
  input wire logic [WIDTH_RESULT-1:0] result_imag_out
);
  logic signed [WIDTH_RESULT-1:0] p_r, p_i;
  logic [2:0] cnt;
  // The reference below models a signed two-stage pipe only
  localparam bit CHECK_ON = (output_latency_cycles == 2) && (a_signedness == 1) &&
    (b_signedness == 1);
  wire go = ena_in && !sclr_in && !aclr_in && cnt[2];
  // Signed reading only; exact while WIDTH_RESULT covers WIDTH_A+WIDTH_B+2
  assign p_r = $signed(a_real_in) * $signed(b_real_in) - $signed(a_imag_in) * $signed(b_imag_in);
  assign p_i = $signed(a_real_in) * $signed(b_imag_in) + $signed(a_imag_in) * $signed(b_real_in);
  // Skips the edges where the synchronised reset copy still clears the pipe
  always @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in) cnt <= 3'h0;
    else if (cnt != 3'h7) cnt <= cnt + 3'h1;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_real_product: assert property ((CHECK_ON && $past(go) && $past(go, 2) && !aclr_in) |->
    result_real_out == $past(p_r, 2)) else $error("real product wrong");
  a_imag_product: assert property ((CHECK_ON && $past(go) && $past(go, 2) && !aclr_in) |->
    result_imag_out == $past(p_i, 2)) else $error("imag product wrong");
  a_latency_not_early: assert property ((CHECK_ON && $past(go) && !aclr_in &&
    $past(p_i) != $past(p_i, 2) && $past(go, 2)) |-> result_imag_out != $past(p_i))
    else $error("product came early");
  a_hold_real: assert property ((CHECK_ON && !ena_in && !sclr_in && !aclr_in && cnt[2]) |=>
    (aclr_in || $stable(result_real_out))) else $error("real moved while disabled");
  a_hold_imag: assert property ((CHECK_ON && !ena_in && !sclr_in && !aclr_in && cnt[2]) |=>
    (aclr_in || $stable(result_imag_out))) else $error("imag moved while disabled");
  a_sync_clear: assert property ((CHECK_ON && sclr_in) |=> result_real_out == '0)
    else $error("sync clear missed");
  a_sync_clear_pipe: assert property ((CHECK_ON && sclr_in ##1 go) |=> result_imag_out == '0)
    else $error("stage left after sync clear");
  a_async_clear: assert property ((CHECK_ON && aclr_in) |->
    {result_real_out, result_imag_out} == '0) else $error("async clear missed");
  c_stream: cover property (go [*3]);
  c_freeze: cover property (!ena_in && cnt[2]);
  c_sclr: cover property (sclr_in ##1 go);
endmodule
bind pcm_complex_mult pcm_props #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B),
  .WIDTH_RESULT(WIDTH_RESULT), .a_signedness(a_signedness), .b_signedness(b_signedness),
  .output_latency_cycles(output_latency_cycles)) pcm_props_i (.*);
`default_nettype wire

// ===== bench/tb_pcm_complex_mult.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcm_complex_mult;
  logic               clk, rst_n, aclr, sclr, ena;
  logic [7:0]         pattern;
  logic [7:0]         tbl [6] = '{8'h80, 8'h7F, 8'h00, 8'hFF, 8'h01, 8'h55};
  wire  [7:0]         ar, ai, br, bi;
  wire  [17:0]        rr, ri, rz, iz;
  logic signed [17:0] er, ei, h1r, h1i, h2r, h2i;
  logic [17:0]        ez_r, ez_i;
  int                 n_fail, n_compared;
  pcm_fabric pcm_fabric_i (.ref_clk_in(clk), .pattern_in(pattern), .a_real_out(ar),
    .a_imag_out(ai), .b_real_out(br), .b_imag_out(bi));
  pcm_complex_mult #(.WIDTH_A(8), .WIDTH_B(8), .WIDTH_RESULT(18), .output_latency_cycles(2))
    pcm_complex_mult_i (.ref_clk_in(clk), .rst_n_in(rst_n), .aclr_in(aclr), .sclr_in(sclr),
    .ena_in(ena), .a_real_in(ar), .a_imag_in(ai), .b_real_in(br), .b_imag_in(bi),
    .result_real_out(rr), .result_imag_out(ri));
  // Second copy: unsigned operands and no register stage at all
  pcm_complex_mult #(.WIDTH_A(8), .WIDTH_B(8), .WIDTH_RESULT(18), .a_signedness(0),
    .b_signedness(0), .output_latency_cycles(0))
    pcm_complex_mult_comb_i (.ref_clk_in(clk), .rst_n_in(rst_n), .aclr_in(aclr),
    .sclr_in(sclr), .ena_in(ena), .a_real_in(ar), .a_imag_in(ai), .b_real_in(br),
    .b_imag_in(bi), .result_real_out(rz), .result_imag_out(iz));
  always @* ez_r = {10'h000, ar} * {10'h000, br} - {10'h000, ai} * {10'h000, bi};
  always @* ez_i = {10'h000, ar} * {10'h000, bi} + {10'h000, ai} * {10'h000, br};
  always @* er = $signed(ar) * $signed(br) - $signed(ai) * $signed(bi);
  always @* ei = $signed(ar) * $signed(bi) + $signed(ai) * $signed(br);
  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Two-deep history mirrors the pipe: clears empty it, a disabled edge freezes it
  task automatic step;
    @(posedge clk);
    if (sclr || aclr) {h1r, h1i, h2r, h2i} = '0;
    else if (ena) {h2r, h2i, h1r, h1i} = {h1r, h1i, er, ei};
    #1;
  endtask
  task automatic both(input string nm);
    chk({nm, " real"}, h2r, rr);
    chk({nm, " imag"}, h2i, ri);
  endtask
  task automatic t_stream;
    for (int i = 0; i < 9; i++) begin
      step;
      pattern = tbl[i % 6];
      both("stream");
    end
  endtask
  task automatic t_freeze;
    ena = 0;
    pattern = 8'h33;
    repeat (3) begin
      step;
      both("freeze");
    end
    ena = 1;
  endtask
  task automatic t_clear;
    sclr = 1;
    step;
    sclr = 0;
    both("sclr");
    step;
    both("sclr pipe");
    // Refill the pipe so the async clear has something to remove
    repeat (2) step;
    aclr = 1;
    {h1r, h1i, h2r, h2i} = '0;
    #1;
    both("aclr");
    step;
    aclr = 0;
    step;
    both("aclr pipe");
  endtask
  // Products of the zero-latency copy must follow the operands in the same cycle
  task automatic t_comb;
    for (int i = 0; i < 6; i++) begin
      pattern = tbl[i];
      step;
      chk("comb real", ez_r, rz);
      chk("comb imag", ez_i, iz);
    end
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, aclr, sclr, ena, pattern, n_fail, n_compared} = '0;
    {h1r, h1i, h2r, h2i} = '0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1;
    ena = 1;
    repeat (4) step;
    t_stream;
    t_freeze;
    t_clear;
    t_stream;
    t_comb;
    final_report;
  end
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
